/* File: hw/rtdc_level_decode.sv */
// Decode of the test level code into direction and step count
module rtdc_level_decode
  import rtdc_pkg::*;
(
  input wire logic [7:0] tst_q, // Stored test voltage control
  output rtdc_pkg::rtdc_tdac_s tdac // Decoded generator controls
);
  import rtdc_pkg::*;

  logic [4:0] lvl;

  assign lvl = tst_q[LEVEL_LSB +: LEVEL_W];

  // Reserved codes hold the generator at the 2.5 V midpoint
  always_comb begin
    tdac = '0;
    tdac.test_output_connect = tst_q[CONNECT_BIT];
    if (lvl == 5'h00) begin
      tdac.level_valid = 1'b1;
    end else if (lvl <= LEVEL_UP_MAX) begin
      tdac.level_valid = 1'b1;
      tdac.level_up = 1'b1;
      tdac.level_step = lvl[3:0];
    end else if (lvl >= LEVEL_DN_MIN && lvl <= LEVEL_DN_MAX) begin
      tdac.level_valid = 1'b1;
      tdac.level_down = 1'b1;
      tdac.level_step = lvl[3:0];
    end
  end
endmodule : rtdc_level_decode

/* File: hw/rtdc_pkg.sv */
// Package: register map, field layout, codes and carriers for the reference and test DAC block
package rtdc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REF_SEL_ADDR = 8'h0F;
  localparam logic [7:0] TST_POS_ADDR = 8'h10;
  localparam logic [7:0] REF_SEL_RESET = 8'h00;
  localparam logic [7:0] TST_POS_RESET = 8'h00;
  localparam int POS_REF_LSB = 3;
  localparam int NEG_REF_LSB = 0;
  localparam int REF_FIELD_W = 3;
  localparam int CONNECT_BIT = 7;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 5;
  localparam logic [7:0] REF_SEL_WMASK = 8'h3F;
  localparam logic [7:0] TST_POS_WMASK = 8'h9F;
  localparam logic [2:0] REF_CODE_MAX = 3'h4;
  localparam logic [4:0] LEVEL_UP_MAX = 5'h09;
  localparam logic [4:0] LEVEL_DN_MIN = 5'h11;
  localparam logic [4:0] LEVEL_DN_MAX = 5'h19;

  typedef enum logic [2:0] {
    RTDC_POS_INTERNAL,
    RTDC_POS_ANALOG_INPUT_0,
    RTDC_POS_ANALOG_INPUT_2,
    RTDC_POS_ANALOG_INPUT_4,
    RTDC_POS_SUPPLY,
    RTDC_POS_NONE
  } rtdc_pos_ref_e;

  typedef enum logic [2:0] {
    RTDC_NEG_INTERNAL,
    RTDC_NEG_ANALOG_INPUT_1,
    RTDC_NEG_ANALOG_INPUT_3,
    RTDC_NEG_ANALOG_INPUT_5,
    RTDC_NEG_SUPPLY,
    RTDC_NEG_NONE
  } rtdc_neg_ref_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rtdc_bus_s;

  typedef struct packed {
    logic test_output_connect;
    logic level_up;
    logic level_down;
    logic [3:0] level_step;
    logic level_valid;
  } rtdc_tdac_s;
endpackage : rtdc_pkg

/* File: hw/rtdc_ref_decode.sv */
// Decode of the reference select register into source selects
module rtdc_ref_decode
  import rtdc_pkg::*;
(
  input wire logic [7:0] sel_q, // Stored reference select
  output rtdc_pkg::rtdc_pos_ref_e pos_ref, // Positive source
  output rtdc_pkg::rtdc_neg_ref_e neg_ref // Negative source
);
  import rtdc_pkg::*;

  logic [2:0] pos_code;
  logic [2:0] neg_code;

  assign pos_code = sel_q[POS_REF_LSB +: REF_FIELD_W];
  assign neg_code = sel_q[NEG_REF_LSB +: REF_FIELD_W];

  // A reserved code opens the switch of its own field rather than guess a source
  always_comb begin
    case (pos_code)
      3'h0: pos_ref = RTDC_POS_INTERNAL;
      3'h1: pos_ref = RTDC_POS_ANALOG_INPUT_0;
      3'h2: pos_ref = RTDC_POS_ANALOG_INPUT_2;
      3'h3: pos_ref = RTDC_POS_ANALOG_INPUT_4;
      3'h4: pos_ref = RTDC_POS_SUPPLY;
      default: pos_ref = RTDC_POS_NONE;
    endcase
  end

  always_comb begin
    case (neg_code)
      3'h0: neg_ref = RTDC_NEG_INTERNAL;
      3'h1: neg_ref = RTDC_NEG_ANALOG_INPUT_1;
      3'h2: neg_ref = RTDC_NEG_ANALOG_INPUT_3;
      3'h3: neg_ref = RTDC_NEG_ANALOG_INPUT_5;
      3'h4: neg_ref = RTDC_NEG_SUPPLY;
      default: neg_ref = RTDC_NEG_NONE;
    endcase
  end
endmodule : rtdc_ref_decode

/* File: hw/rtdc_top.sv */
// Reference select and positive test voltage configuration registers
//
// Summary of operation
// - Bits 5:3 pick positive reference source
// - Bits 2:0 pick negative reference source
// - Reference select at 0Fh, resets zero
// - Test voltage register at 10h, resets zero
// - Bit 7 connects test output to input 6
// - Bits 4:0 pick test level around 2.5V
//
// Chosen here: the plain strobed port.
module rtdc_top
  import rtdc_pkg::*;
(
  input wire logic clk, // 50 MHz core clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [rtdc_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [rtdc_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [rtdc_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  output rtdc_pkg::rtdc_pos_ref_e pos_ref, // Positive reference select
  output rtdc_pkg::rtdc_neg_ref_e neg_ref, // Negative reference select
  output rtdc_pkg::rtdc_tdac_s tdac, // Test generator controls
  output logic level_reserved // Reserved level code stored
);
  import rtdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  rtdc_bus_s bus;
  logic [7:0] ref_sel_q;
  logic [7:0] tst_pos_q;
  logic [7:0] ref_sel_d;
  logic [7:0] tst_pos_d;
  logic [7:0] rdata_d;
  logic [7:0] reg_rdata_q;
  logic [7:0] ref_pos_q;
  logic [7:0] tst_pos_pos_q;
  logic ref_sel_hit;
  logic tst_pos_hit;
  logic ref_sel_we;
  logic tst_pos_we;
  logic [2:0] pos_field;
  logic [2:0] neg_field;
  logic [4:0] lvl_field;

  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction : masked

  // Codes above the supply choice are reserved in both reference fields
  function automatic logic ref_legal(input logic [2:0] code);
    ref_legal = (code <= REF_CODE_MAX);
  endfunction : ref_legal

  // Host is trusted to keep to these; the rest are reserved
  function automatic logic level_legal(input logic [4:0] code);
    level_legal = (code <= LEVEL_UP_MAX) || (code >= LEVEL_DN_MIN && code <= LEVEL_DN_MAX);
  endfunction : level_legal

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign ref_sel_hit = (bus.addr == REF_SEL_ADDR);
  assign tst_pos_hit = (bus.addr == TST_POS_ADDR);

  // One qualified enable per register keeps the address decode in one place
  assign ref_sel_we = bus.wr && ref_sel_hit;
  assign tst_pos_we = bus.wr && tst_pos_hit;

  ////////////////////////////////////////////////////////////////////////
  // Reserved bits are dropped on write so they can never read back set
  assign ref_sel_d = masked(bus.wdata, REF_SEL_WMASK);
  assign tst_pos_d = masked(bus.wdata, TST_POS_WMASK);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_sel_q <= REF_SEL_RESET;
    end else if (ref_sel_we) begin
      ref_sel_q <= ref_sel_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_pos_q <= TST_POS_RESET;
    end else if (tst_pos_we) begin
      tst_pos_q <= tst_pos_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unmapped addresses read zero; data stands one cycle only
  always_comb begin
    rdata_d = 8'h00;
    if (ref_sel_hit) begin
      rdata_d = ref_sel_q;
    end else if (tst_pos_hit) begin
      rdata_d = tst_pos_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else if (bus.rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_q;

  ////////////////////////////////////////////////////////////////////////
  rtdc_ref_decode u_ref_decode (
    .sel_q(ref_sel_q),
    .pos_ref(pos_ref),
    .neg_ref(neg_ref)
  );

  rtdc_level_decode u_level_decode (
    .tst_q(tst_pos_q),
    .tdac(tdac)
  );

  // Flag only; the host is trusted to avoid reserved level codes
  assign level_reserved = !tdac.level_valid;

  ////////////////////////////////////////////////////////////////////////
  // Helper history for the checks below
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_pos_q <= 8'h00;
    end else begin
      ref_pos_q <= ref_sel_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_pos_pos_q <= 8'h00;
    end else begin
      tst_pos_pos_q <= tst_pos_q;
    end
  end

  // Field views shared by the decode checks
  assign pos_field = ref_sel_q[POS_REF_LSB +: REF_FIELD_W];
  assign neg_field = ref_sel_q[NEG_REF_LSB +: REF_FIELD_W];
  assign lvl_field = tst_pos_q[LEVEL_LSB +: LEVEL_W];

  ref_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && ref_sel_hit |=> ref_sel_q == ($past(bus.wdata) & 8'h3F))
    else $error("reference select write not stored");

  tst_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && tst_pos_hit |=> tst_pos_q == ($past(bus.wdata) & 8'h9F))
    else $error("test voltage write not stored");

  ref_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(bus.wr && ref_sel_hit) |=> $stable(ref_sel_q))
    else $error("reference select changed without write");

  read_data_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && ref_sel_hit && !bus.wr |=> reg_rdata == ref_pos_q && reg_rdata[7:6] == 2'h0)
    else $error("reference select read back wrong");

  read_tst_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && tst_pos_hit |=> reg_rdata == tst_pos_pos_q && reg_rdata[6:5] == 2'h0)
    else $error("test voltage read back wrong");

  read_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !bus.rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  pos_ref_a: assert property (@(posedge clk) disable iff (!reset_n)
    ref_sel_q[5:3] <= REF_CODE_MAX |-> pos_ref == rtdc_pos_ref_e'(ref_sel_q[5:3]))
    else $error("positive reference decode wrong");

  neg_ref_a: assert property (@(posedge clk) disable iff (!reset_n)
    ref_sel_q[2:0] > REF_CODE_MAX |-> neg_ref == RTDC_NEG_NONE)
    else $error("negative reservation decode wrong");

  connect_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && tst_pos_hit |=> tdac.test_output_connect == $past(bus.wdata[7]))
    else $error("connect enable wrong");

  level_a: assert property (@(posedge clk) disable iff (!reset_n)
    tst_pos_q[4:0] == 5'h19 |-> tdac.level_down && tdac.level_step == 4'h9)
    else $error("lowest level decode wrong");

  midpoint_a: assert property (@(posedge clk) disable iff (!reset_n)
    tst_pos_q[4:0] == 5'h00 |-> !tdac.level_up && !tdac.level_down && !level_reserved)
    else $error("midpoint decode wrong");

  ////////////////////////////////////////////////////////////////////////
  // Write path: only a matching strobe may move a register
  tst_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !tst_pos_we
    |=> $stable(tst_pos_q))
    else $error("test voltage changed without write");

  unmapped_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.wr && !ref_sel_hit && !tst_pos_hit
    |=> $stable(ref_sel_q) && $stable(tst_pos_q))
    else $error("unmapped write changed a register");

  ref_rsv_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ref_sel_q & ~REF_SEL_WMASK) == 8'h00)
    else $error("reference select reserved bits set");

  tst_rsv_a: assert property (@(posedge clk) disable iff (!reset_n)
    (tst_pos_q & ~TST_POS_WMASK) == 8'h00)
    else $error("test voltage reserved bits set");

  // Read path: the answer stands in the cycle after the strobe only
  read_unmapped_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus.rd && !ref_sel_hit && !tst_pos_hit
    |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");

  ref_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
    ref_sel_we ##1 !bus.wr ##1 (bus.rd && ref_sel_hit && !bus.wr)
    |=> reg_rdata == ($past(bus.wdata, 3) & REF_SEL_WMASK))
    else $error("reference select write not read back");

  tst_readback_a: assert property (@(posedge clk) disable iff (!reset_n)
    tst_pos_we ##1 !bus.wr ##1 (bus.rd && tst_pos_hit && !bus.wr)
    |=> reg_rdata == ($past(bus.wdata, 3) & TST_POS_WMASK))
    else $error("test voltage write not read back");

  // Reference decode: reserved codes must open the switches
  pos_rsv_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ref_legal(pos_field)
    |-> pos_ref == RTDC_POS_NONE)
    else $error("positive reservation decode wrong");

  neg_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
    ref_legal(neg_field)
    |-> neg_ref == rtdc_neg_ref_e'(neg_field))
    else $error("negative reference decode wrong");

  pos_supply_a: assert property (@(posedge clk) disable iff (!reset_n)
    pos_field == REF_CODE_MAX
    |-> pos_ref == RTDC_POS_SUPPLY)
    else $error("positive supply decode wrong");

  neg_supply_a: assert property (@(posedge clk) disable iff (!reset_n)
    neg_field == REF_CODE_MAX
    |-> neg_ref == RTDC_NEG_SUPPLY)
    else $error("negative supply decode wrong");

  ref_default_a: assert property (@(posedge clk) disable iff (!reset_n)
    ref_sel_q == REF_SEL_RESET
    |-> pos_ref == RTDC_POS_INTERNAL && neg_ref == RTDC_NEG_INTERNAL)
    else $error("default reference decode wrong");

  ref_out_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ref_sel_we
    |=> $stable(pos_ref) && $stable(neg_ref))
    else $error("reference select moved without write");

  // Test generator decode
  connect_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    tdac.test_output_connect == tst_pos_q[CONNECT_BIT])
    else $error("connect enable does not follow register");

  tst_default_a: assert property (@(posedge clk) disable iff (!reset_n)
    tst_pos_q == TST_POS_RESET
    |-> !tdac.test_output_connect && tdac.level_valid)
    else $error("default test generator state wrong");

  level_up_a: assert property (@(posedge clk) disable iff (!reset_n)
    lvl_field inside {[5'h01:LEVEL_UP_MAX]}
    |-> tdac.level_up && !tdac.level_down && tdac.level_step == lvl_field[3:0])
    else $error("rising level decode wrong");

  level_down_a: assert property (@(posedge clk) disable iff (!reset_n)
    lvl_field inside {[LEVEL_DN_MIN:LEVEL_DN_MAX]}
    |-> tdac.level_down && !tdac.level_up && tdac.level_step == lvl_field[3:0])
    else $error("falling level decode wrong");

  level_rsv_a: assert property (@(posedge clk) disable iff (!reset_n)
    !level_legal(lvl_field)
    |-> level_reserved && !tdac.level_up && !tdac.level_down && tdac.level_step == 4'h0)
    else $error("reserved level not held at midpoint");

  level_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    level_legal(lvl_field)
    |-> !level_reserved && tdac.level_valid)
    else $error("legal level flagged reserved");

  step_range_a: assert property (@(posedge clk) disable iff (!reset_n)
    tdac.level_valid
    |-> tdac.level_step <= LEVEL_UP_MAX[3:0])
    else $error("level step out of range");

  tdac_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
    !tst_pos_we
    |=> $stable(tdac))
    else $error("test generator moved without write");

  cover_ref_c: cover property (@(posedge clk) disable iff (!reset_n)
    bus.wr && ref_sel_hit ##1 bus.rd && ref_sel_hit);
  cover_conn_c: cover property (@(posedge clk) disable iff (!reset_n)
    tdac.test_output_connect && tdac.level_up);
  cover_rsv_c: cover property (@(posedge clk) disable iff (!reset_n) level_reserved);
  cover_down_c: cover property (@(posedge clk) disable iff (!reset_n)
    tdac.test_output_connect && tdac.level_down);
  cover_none_c: cover property (@(posedge clk) disable iff (!reset_n)
    pos_ref == RTDC_POS_NONE && neg_ref != RTDC_NEG_NONE);
endmodule : rtdc_top

/* File: testbench/tb_rtdc_top.sv */
// Self-checking bench for the reference select and test voltage registers
module tb_rtdc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rtdc_pkg::*;

  logic clk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  rtdc_pos_ref_e pos_ref;
  rtdc_neg_ref_e neg_ref;
  rtdc_tdac_s tdac;
  logic level_reserved;
  int err_count;
  int total_checks;

  rtdc_top i_dut (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .pos_ref(pos_ref),
    .neg_ref(neg_ref),
    .tdac(tdac),
    .level_reserved(level_reserved)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Decoded outputs are combinational, so look just after the write edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, m);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_vals;
    chk({5'h00, pos_ref}, 8'h00, "pos ref after reset");
    chk({5'h00, neg_ref}, 8'h00, "neg ref after reset");
    chk(tdac, 8'h01, "tdac after reset");
    chk({7'h00, level_reserved}, 8'h00, "reserved flag after reset");
    rd(8'h0F, 8'h00, "ref sel reset value");
    rd(8'h10, 8'h00, "test reg reset value");
  endtask : reset_vals

  task automatic ref_codes;
    logic [2:0] p;
    logic [2:0] n;
    for (int i = 0; i < 8; i++) begin
      p = i[2:0];
      n = 3'h7 - p;
      wr(8'h0F, {2'h3, p, n});
      chk({5'h00, pos_ref}, (p <= 3'h4) ? {5'h00, p} : 8'h05, "pos ref decode");
      chk({5'h00, neg_ref}, (n <= 3'h4) ? {5'h00, n} : 8'h05, "neg ref decode");
      rd(8'h0F, {2'h0, p, n}, "ref sel readback");
    end
  endtask : ref_codes

  task automatic level_codes;
    logic [4:0] c;
    logic up;
    logic dn;
    logic ok;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      up = (c >= 5'h01) && (c <= 5'h09);
      dn = (c >= 5'h11) && (c <= 5'h19);
      ok = up || dn || (c == 5'h00);
      wr(8'h10, {i[0], 2'h3, c});
      chk(tdac, {i[0], up, dn, ok ? c[3:0] : 4'h0, ok}, "level decode");
      chk({7'h00, level_reserved}, {7'h00, !ok}, "reserved level flag");
      rd(8'h10, {i[0], 2'h0, c}, "test reg readback");
    end
  endtask : level_codes

  // Unmapped places must neither store nor answer; then an async reset
  task automatic unmapped_and_reset;
    wr(8'h0F, 8'h21);
    wr(8'h11, 8'hFF);
    wr(8'h0E, 8'hFF);
    rd(8'h11, 8'h00, "unmapped read");
    rd(8'h0F, 8'h21, "ref sel kept");
    @(posedge clk);
    #1;
    chk(reg_rdata, 8'h00, "read data released");
    chk({5'h00, pos_ref}, 8'h04, "pos ref supply");
    // A synchronous clear would still show the old value just after this edge
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    chk({5'h00, pos_ref}, 8'h00, "async reset clears");
    chk(tdac, 8'h01, "tdac after mid reset");
    @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h0F, 8'h00, "ref sel after reset");
    rd(8'h10, 8'h00, "test reg after reset");
  endtask : unmapped_and_reset

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is about 3.7 microseconds; 50 us, over thirteen times that, is a hang
  initial begin
    #50000;
    err_count++;
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    reset_vals();
    ref_codes();
    level_codes();
    unmapped_and_reset();
    report_and_stop();
  end
endmodule : tb_rtdc_top
